// >>> pkg/mpc_consts.vh
// Functional notes
// - Bit 7 of misc config starts converter with capacitor discharge sequence.
// - Bit 6 delays converter power-up by the interval bit 5 selects.
// - Bit 5 picks delay: 0 gives 64-128 ms, 1 gives 256-512 ms.
// - Bit 4 asserts hard reset after selected clock missing for 2 ms.
// - Misc config bits 3-0 read zero; software writes only zero there.
// - Pin function 0 off, 1 input, 2 general output, 3 interrupt; reset 3.
// - Codes 4, 5, 6 route PDM clock, primary data, secondary data.
// - Code 9 drives secondary bit clock, code 10 general clock out.
// - Code 12 muxes both data outputs; daisy out offered; 14-15 reserved.
// - Drive field sets output stage; reset 2; codes 6-7 reserved.
// - Drive field ignored while pin carries serial data output.
// - Pin config bit 3 reads zero; software writes only zero there.
`ifndef MPC_CONSTS_VH
`define MPC_CONSTS_VH
// ----------------------------------------
// Register indexes, byte address is four times index
// ----------------------------------------
`define MPC_IDX_MISC      8'h07
`define MPC_IDX_PIN1      8'h0a
`define MPC_IDX_OUTPIN    8'h0c
`define MPC_IDX_CTRL      8'h10
`define MPC_IDX_STATUS    8'h11
// ----------------------------------------
// Reset values and field positions
// ----------------------------------------
`define MPC_RST_MISC      8'h00
`define MPC_RST_PIN1      8'h32
`define MPC_RST_OUTPIN    8'h00
`define MPC_MISC_WMASK    8'hf0
`define MPC_PIN1_WMASK    8'hf7
`define MPC_BIT_DISCH     7
`define MPC_BIT_DLYEN     6
`define MPC_BIT_DLYSEL    5
`define MPC_BIT_CLKRST    4
// ----------------------------------------
// Pin function codes
// ----------------------------------------
`define MPC_FN_OFF        4'h0
`define MPC_FN_IN         4'h1
`define MPC_FN_GPO        4'h2
`define MPC_FN_IRQ        4'h3
`define MPC_FN_PDM        4'h4
`define MPC_FN_PDOUT      4'h5
`define MPC_FN_SDOUT      4'h6
`define MPC_FN_SBCLK      4'h9
`define MPC_FN_CLKO       4'ha
`define MPC_FN_MUXD       4'hc
`define MPC_FN_DAISY      4'hd
// ----------------------------------------
// Timing, 250 MHz clock
// ----------------------------------------
`define MPC_CLK_KHZ       250000
`define MPC_DLY_SHORT_MS  64
`define MPC_DLY_LONG_MS   256
`define MPC_CLKLOSS_MS    2
`define MPC_DLY_SHORT_CYC (`MPC_DLY_SHORT_MS * `MPC_CLK_KHZ)
`define MPC_DLY_LONG_CYC  (`MPC_DLY_LONG_MS * `MPC_CLK_KHZ)
`define MPC_CLKLOSS_CYC   (`MPC_CLKLOSS_MS * `MPC_CLK_KHZ)
`define MPC_CAPDIS_CYC    16
`define MPC_RSTPULSE_CYC  16
`endif

// >>> rtl/mpc_pin_drive.v
`timescale 1ns/1ns
`include "mpc_consts.vh"
module mpc_pin_drive (
  // Selected level and drive mode
  input  wire       level,
  input  wire [2:0] drive,
  // Pin stage
  output reg        pin_o,
  output reg        pin_oe,
  output reg        weak_pull_up,
  output reg        weak_pull_dn
);
  // ----------------------------------------
  // Output stage decode
  // ----------------------------------------
  always @* begin
    pin_o        = level;
    pin_oe       = 1'b0;
    weak_pull_up = 1'b0;
    weak_pull_dn = 1'b0;
    case (drive)
      3'h1: pin_oe = 1'b1;
      3'h2: begin
        pin_oe       = ~level;
        weak_pull_up = level;
      end
      3'h3: pin_oe = ~level;
      3'h4: begin
        pin_oe       = level;
        weak_pull_dn = ~level;
      end
      3'h5: pin_oe = level;
      default: pin_oe = 1'b0;
    endcase
  end
endmodule // mpc_pin_drive

// >>> rtl/mpc_regs.v
`timescale 1ns/1ns
`include "mpc_consts.vh"
module mpc_regs #(
  parameter [31:0] SHORT_DLY_CYC = `MPC_DLY_SHORT_CYC,
  parameter [31:0] LONG_DLY_CYC  = `MPC_DLY_LONG_CYC,
  parameter [31:0] CLKLOSS_CYC   = `MPC_CLKLOSS_CYC
) (
  // Clock and reset
  input  wire        clk,
  input  wire        rst_b,
  // Avalon-MM slave
  input  wire [7:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  // Converter control
  input  wire        converter_start,
  input  wire        selected_clock_in,
  output reg         cap_discharge_ff,
  output reg         converter_power_ff,
  output reg         hard_reset_ff,
  // Pin sources
  input  wire        gpo_level,
  input  wire        irq_level,
  input  wire        pdm_clock_out,
  input  wire        primary_serial_data_out,
  input  wire        secondary_serial_data_out,
  input  wire        secondary_bit_clock,
  input  wire        general_clock_out,
  input  wire        serial_data_mux_sel,
  input  wire        daisy_data_out,
  // Multi-purpose pin 1
  input  wire        multi_purpose_pin_1_i,
  output reg         multi_purpose_pin_1_o,
  output reg         multi_purpose_pin_1_oe,
  output reg         pin1_weak_up_ff,
  output reg         pin1_weak_dn_ff,
  output reg         pin1_input_ff
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg  [7:0]  misc_ff;
  reg  [7:0]  pin1_ff;
  reg  [7:0]  outpin_ff;
  reg         ack_ff;
  reg  [31:0] dly_cnt_ff;
  reg  [31:0] loss_cnt_ff;
  reg  [4:0]  dis_cnt_ff;
  reg  [4:0]  rp_cnt_ff;
  reg  [1:0]  st_ff;
  reg  [2:0]  ck_sync_ff;
  reg  [2:0]  in_sync_ff;
  reg         ck_last_ff;
  reg         start_last_ff;
  reg         sel_level;
  reg  [2:0]  sel_drive;
  reg         serial_fn;
  wire        pin_o;
  wire        pin_oe;
  wire        w_up;
  wire        w_dn;
  wire        wr_hit;
  wire        ck_edge;
  wire [31:0] dly_target;

  localparam [1:0] ST_OFF   = 2'h0;
  localparam [1:0] ST_DISCH = 2'h1;
  localparam [1:0] ST_DELAY = 2'h2;
  localparam [1:0] ST_ON    = 2'h3;

  function [7:0] merge;
    input [7:0] old_v;
    input [7:0] new_v;
    input [7:0] wmask;
    begin
      merge = (old_v & ~wmask) | (new_v & wmask);
    end
  endfunction

  // ----------------------------------------
  // Bus slave, one wait cycle per access
  // ----------------------------------------
  assign wr_hit = avs_write & ~ack_ff & avs_byteenable[0];

  always @(posedge clk) begin
    if (!rst_b) begin
      ack_ff          <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0;
      misc_ff         <= `MPC_RST_MISC;
      pin1_ff         <= `MPC_RST_PIN1;
      outpin_ff       <= `MPC_RST_OUTPIN;
    end else begin
      ack_ff          <= (avs_read | avs_write) & ~ack_ff;
      avs_waitrequest <= ~((avs_read | avs_write) & ~ack_ff);
      if (wr_hit) begin
        case (avs_address)
          `MPC_IDX_MISC:   misc_ff <= merge(misc_ff, avs_writedata[7:0],
                                            `MPC_MISC_WMASK);
          `MPC_IDX_PIN1:   pin1_ff <= merge(pin1_ff, avs_writedata[7:0],
                                            `MPC_PIN1_WMASK);
          `MPC_IDX_OUTPIN: outpin_ff <= avs_writedata[7:0];
          default: ;
        endcase
      end
      if (avs_read & ~ack_ff) begin
        case (avs_address)
          `MPC_IDX_MISC:   avs_readdata <= {24'h0, misc_ff};
          `MPC_IDX_PIN1:   avs_readdata <= {24'h0, pin1_ff};
          `MPC_IDX_OUTPIN: avs_readdata <= {24'h0, outpin_ff};
          `MPC_IDX_STATUS: avs_readdata <= {27'h0, pin1_input_ff, hard_reset_ff,
                                            st_ff, cap_discharge_ff};
          default:         avs_readdata <= 32'h0;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Converter start sequence
  // ----------------------------------------
  assign dly_target = misc_ff[`MPC_BIT_DLYSEL] ? LONG_DLY_CYC : SHORT_DLY_CYC;

  always @(posedge clk) begin
    if (!rst_b) begin
      st_ff              <= ST_OFF;
      start_last_ff      <= 1'b0;
      dis_cnt_ff         <= 5'h0;
      dly_cnt_ff         <= 32'h0;
      cap_discharge_ff   <= 1'b0;
      converter_power_ff <= 1'b0;
    end else begin
      start_last_ff <= converter_start;
      case (st_ff)
        ST_OFF: begin
          dis_cnt_ff <= 5'h0;
          dly_cnt_ff <= 32'h0;
          if (converter_start & ~start_last_ff) begin
            if (misc_ff[`MPC_BIT_DISCH]) begin
              st_ff            <= ST_DISCH;
              cap_discharge_ff <= 1'b1;
            end else if (misc_ff[`MPC_BIT_DLYEN]) begin
              st_ff <= ST_DELAY;
            end else begin
              st_ff              <= ST_ON;
              converter_power_ff <= 1'b1;
            end
          end
        end
        ST_DISCH: begin
          dis_cnt_ff <= dis_cnt_ff + 5'h1;
          if (dis_cnt_ff == `MPC_CAPDIS_CYC - 1) begin
            cap_discharge_ff <= 1'b0;
            if (misc_ff[`MPC_BIT_DLYEN]) begin
              st_ff <= ST_DELAY;
            end else begin
              st_ff              <= ST_ON;
              converter_power_ff <= 1'b1;
            end
          end
        end
        ST_DELAY: begin
          dly_cnt_ff <= dly_cnt_ff + 32'h1;
          if (dly_cnt_ff >= dly_target - 32'h1) begin
            st_ff              <= ST_ON;
            converter_power_ff <= 1'b1;
          end
        end
        ST_ON: begin
          if (!converter_start) begin
            st_ff              <= ST_OFF;
            converter_power_ff <= 1'b0;
          end
        end
        default: st_ff <= ST_OFF;
      endcase
    end
  end

  // ----------------------------------------
  // Clock loss watchdog
  // ----------------------------------------
  assign ck_edge = (ck_sync_ff[1] == ck_sync_ff[2]) & (ck_sync_ff[2] != ck_last_ff);

  always @(posedge clk) begin
    if (!rst_b) begin
      ck_sync_ff    <= 3'h0;
      ck_last_ff    <= 1'b0;
      loss_cnt_ff   <= 32'h0;
      rp_cnt_ff     <= 5'h0;
      hard_reset_ff <= 1'b0;
    end else begin
      ck_sync_ff <= {ck_sync_ff[1:0], selected_clock_in};
      if (ck_sync_ff[1] == ck_sync_ff[2])
        ck_last_ff <= ck_sync_ff[2];
      if (ck_edge | ~misc_ff[`MPC_BIT_CLKRST])
        loss_cnt_ff <= 32'h0;
      else if (loss_cnt_ff != CLKLOSS_CYC)
        loss_cnt_ff <= loss_cnt_ff + 32'h1;
      if (hard_reset_ff) begin
        rp_cnt_ff <= rp_cnt_ff + 5'h1;
        if (rp_cnt_ff == `MPC_RSTPULSE_CYC - 1) begin
          hard_reset_ff <= 1'b0;
          rp_cnt_ff     <= 5'h0;
        end
      end else if (misc_ff[`MPC_BIT_CLKRST] && loss_cnt_ff == CLKLOSS_CYC - 1) begin
        hard_reset_ff <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Pin function select
  // ----------------------------------------
  always @* begin
    sel_level = 1'b0;
    sel_drive = pin1_ff[2:0];
    serial_fn = 1'b0;
    case (pin1_ff[7:4])
      `MPC_FN_OFF:   sel_drive = 3'h0;
      `MPC_FN_IN:    sel_drive = 3'h0;
      `MPC_FN_GPO:   sel_level = gpo_level;
      `MPC_FN_IRQ:   sel_level = irq_level;
      `MPC_FN_PDM:   sel_level = pdm_clock_out;
      `MPC_FN_PDOUT: begin
        sel_level = primary_serial_data_out;
        serial_fn = 1'b1;
      end
      `MPC_FN_SDOUT: begin
        sel_level = secondary_serial_data_out;
        serial_fn = 1'b1;
      end
      `MPC_FN_SBCLK: sel_level = secondary_bit_clock;
      `MPC_FN_CLKO:  sel_level = general_clock_out;
      `MPC_FN_MUXD: begin
        sel_level = serial_data_mux_sel ? secondary_serial_data_out
                                        : primary_serial_data_out;
        serial_fn = 1'b1;
      end
      `MPC_FN_DAISY: begin
        sel_level = daisy_data_out;
        serial_fn = 1'b1;
      end
      default:       sel_drive = 3'h0;
    endcase
    if (serial_fn)
      sel_drive = 3'h1;
  end

  mpc_pin_drive u_drive (
    .level        (sel_level),
    .drive        (sel_drive),
    .pin_o        (pin_o),
    .pin_oe       (pin_oe),
    .weak_pull_up (w_up),
    .weak_pull_dn (w_dn)
  );

  always @(posedge clk) begin
    if (!rst_b) begin
      multi_purpose_pin_1_o  <= 1'b0;
      multi_purpose_pin_1_oe <= 1'b0;
      pin1_weak_up_ff        <= 1'b0;
      pin1_weak_dn_ff        <= 1'b0;
      in_sync_ff             <= 3'h0;
      pin1_input_ff          <= 1'b0;
    end else begin
      multi_purpose_pin_1_o  <= pin_o;
      multi_purpose_pin_1_oe <= pin_oe;
      pin1_weak_up_ff        <= w_up;
      pin1_weak_dn_ff        <= w_dn;
      in_sync_ff             <= {in_sync_ff[1:0], multi_purpose_pin_1_i};
      if (in_sync_ff[1] == in_sync_ff[2])
        pin1_input_ff <= in_sync_ff[2];
    end
  end
endmodule // mpc_regs

// >>> test/mpc_regs_props.sv
`timescale 1ns/1ns
`include "mpc_consts.vh"
module mpc_regs_props (
  // Clock and reset
  input wire        clk,
  input wire        rst_b,
  // Bus
  input wire [7:0]  avs_address,
  input wire        avs_read,
  input wire        avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0]  avs_byteenable,
  input wire [31:0] avs_readdata,
  input wire        avs_waitrequest,
  // Converter and pin
  input wire        cap_discharge_ff,
  input wire        converter_power_ff,
  input wire        hard_reset_ff,
  input wire        gpo_level,
  input wire        primary_serial_data_out,
  input wire        multi_purpose_pin_1_o,
  input wire        multi_purpose_pin_1_oe,
  input wire        pin1_weak_up_ff
);
  // ----------------------------------------
  // Pin config shadow and checks
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  reg  [6:0] cfg_ff;
  wire       oe = multi_purpose_pin_1_oe;
  wire       po = multi_purpose_pin_1_o;
  wire       gl = gpo_level;
  wire       rd_ok = !avs_waitrequest && avs_read;
  wire       pin_wr = !avs_waitrequest && avs_write && avs_byteenable[0]
                      && avs_address == `MPC_IDX_PIN1;
  always @(posedge clk) begin
    if (!rst_b)
      cfg_ff <= 7'h1a;
    else if (pin_wr)
      cfg_ff <= {avs_writedata[7:4], avs_writedata[2:0]};
  end
  property p_misc_rsv;
    rd_ok && avs_address == `MPC_IDX_MISC |-> avs_readdata[3:0] == 4'h0; endproperty
  a_misc_rsv: assert property (p_misc_rsv) else $error("misc low bits set");
  property p_pin_rsv;
    rd_ok && avs_address == `MPC_IDX_PIN1 |-> !avs_readdata[3]; endproperty
  a_pin_rsv: assert property (p_pin_rsv) else $error("pin bit 3 set");
  property p_off;
    cfg_ff[6:3] <= 4'h1 || cfg_ff[6:3] == 4'h7 || cfg_ff[6:3] == 4'h8
      || cfg_ff[6:3] == 4'hb || cfg_ff[6:3] >= 4'he |-> !oe; endproperty
  a_off: assert property (p_off) else $error("idle pin driven");
  property p_gpo;
    cfg_ff == 7'h11 |-> oe && po == $past(gl); endproperty
  a_gpo: assert property (p_gpo) else $error("gpo push-pull wrong");
  property p_ser;
    cfg_ff[6:3] == 4'h5 |-> oe && po == $past(primary_serial_data_out); endproperty
  a_ser: assert property (p_ser) else $error("serial data wrong");
  property p_drv3;
    cfg_ff == 7'h13 |-> oe == !$past(gl); endproperty
  a_drv3: assert property (p_drv3) else $error("low-only drive wrong");
  property p_weak;
    cfg_ff == 7'h12 |-> pin1_weak_up_ff == $past(gl) && oe != $past(gl); endproperty
  a_weak: assert property (p_weak) else $error("weak high drive wrong");
  property p_rst;
    $rose(hard_reset_ff) |-> hard_reset_ff[*8] ##1 hard_reset_ff[*8] ##1 !hard_reset_ff;
  endproperty
  a_rst: assert property (p_rst) else $error("hard reset pulse length");
  property p_disch;
    $rose(cap_discharge_ff) |-> cap_discharge_ff[*8] ##1 cap_discharge_ff[*8]
      ##1 !cap_discharge_ff;
  endproperty
  a_disch: assert property (p_disch) else $error("discharge length");
  c_pin_wr: cover property (pin_wr);
  c_hrst: cover property ($rose(hard_reset_ff));
  c_pwr: cover property ($rose(converter_power_ff));
endmodule // mpc_regs_props

bind mpc_regs mpc_regs_props u_props (.clk(clk), .rst_b(rst_b), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .cap_discharge_ff(cap_discharge_ff),
  .converter_power_ff(converter_power_ff), .hard_reset_ff(hard_reset_ff),
  .gpo_level(gpo_level), .primary_serial_data_out(primary_serial_data_out),
  .multi_purpose_pin_1_o(multi_purpose_pin_1_o), .pin1_weak_up_ff(pin1_weak_up_ff),
  .multi_purpose_pin_1_oe(multi_purpose_pin_1_oe));

// >>> test/tb.sv
`timescale 1ns/1ns
`include "mpc_consts.vh"
module tb;
  // ----------------------------------------
  // Bench
  // ----------------------------------------
  reg         clk = 1'b0;
  reg         rst_b = 1'b0;
  reg  [7:0]  adr = 8'h00;
  reg         rd = 1'b0;
  reg         wr = 1'b0;
  reg  [31:0] wdat = 32'h0;
  reg         start = 1'b0;
  reg         sclk = 1'b0;
  reg         run = 1'b1;
  reg  [9:0]  src = 10'h0;
  reg  [31:0] q;
  reg  [7:0]  v;
  reg  [7:0]  a;
  reg         saw;
  reg  [47:0] ctab = 48'h00804060c0e0;
  wire [31:0] rdata;
  wire        wt, disch, pwr, hrst;
  wire [3:0]  pin;
  wire        pin_in;
  integer     n_fail = 0, checks_done = 0, cyc = 0, i, j, n, e;
  always #2 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (run && cyc % 3 == 0)
      sclk <= ~sclk;
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      final_report;
    end
  end
  mpc_regs #(.SHORT_DLY_CYC(32'd20), .LONG_DLY_CYC(32'd40), .CLKLOSS_CYC(32'd30)) u_mpc_regs (
    .clk(clk), .rst_b(rst_b), .avs_address(adr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wdat), .avs_byteenable(4'hf), .avs_readdata(rdata), .avs_waitrequest(wt),
    .converter_start(start), .selected_clock_in(sclk), .cap_discharge_ff(disch),
    .converter_power_ff(pwr), .hard_reset_ff(hrst), .gpo_level(src[0]), .irq_level(src[1]),
    .pdm_clock_out(src[2]), .primary_serial_data_out(src[3]),
    .secondary_serial_data_out(src[4]), .secondary_bit_clock(src[5]),
    .general_clock_out(src[6]), .serial_data_mux_sel(src[7]), .daisy_data_out(src[8]),
    .multi_purpose_pin_1_i(src[9]), .multi_purpose_pin_1_o(pin[2]),
    .multi_purpose_pin_1_oe(pin[3]), .pin1_weak_up_ff(pin[1]), .pin1_weak_dn_ff(pin[0]),
    .pin1_input_ff(pin_in));
  // Expected {oe, driven level, weak up, weak down}
  function [3:0] pexp(input [3:0] fn, input [2:0] dv, input [9:0] s);
    reg       l;
    reg       ok;
    reg [2:0] d;
    begin
      ok = 1'b1;
      l = 1'b0;
      case (fn)
        4'h2: l = s[0];
        4'h3: l = s[1];
        4'h4: l = s[2];
        4'h5: l = s[3];
        4'h6: l = s[4];
        4'h9: l = s[5];
        4'ha: l = s[6];
        4'hc: l = s[7] ? s[4] : s[3];
        4'hd: l = s[8];
        default: ok = 1'b0;
      endcase
      d = (fn == 4'h5 || fn == 4'h6 || fn >= 4'hc) ? 3'h1 : dv;
      pexp[3] = ok && (d == 3'h1 || (d == 3'h2 || d == 3'h3) && !l
                       || (d == 3'h4 || d == 3'h5) && l);
      pexp[2] = l;
      pexp[1] = ok && d == 3'h2 && l;
      pexp[0] = ok && d == 3'h4 && !l;
    end
  endfunction
  task chk(input [95:0] nm, input [31:0] seen, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        n_fail = n_fail + 1;
        $display("mismatch %0s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task bus(input w, input [7:0] ad, input [31:0] d);
    begin
      adr <= ad;
      wdat <= d;
      wr <= w;
      rd <= !w;
      @(posedge clk);
      while (wt !== 1'b0)
        @(posedge clk);
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge clk);
    end
  endtask
  task final_report;
    begin
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  initial begin
    i = $urandom(32'h2940880c);
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    src <= $urandom;
    repeat (2) @(posedge clk);
    chk("pin_rst", pin, pexp(4'h3, 3'h2, src));
    bus(1'b0, 8'h20, 32'h0);
    chk("unmapped", q, 32'h0);
    for (i = 0; i < 3; i = i + 1) begin
      a = (i == 0) ? `MPC_IDX_MISC : (i == 1) ? `MPC_IDX_PIN1 : `MPC_IDX_OUTPIN;
      bus(1'b0, a, 32'h0);
      chk("reg_rst", q, (i == 1) ? 32'h32 : 32'h0);
      v = $urandom;
      if (i == 0)
        v = 8'hf0;
      else if (i == 1)
        v = {v[7:4] % 4'he, 1'b0, v[2:0]};
      bus(1'b1, a, {24'h0, v});
      bus(1'b0, a, 32'h0);
      chk("reg_rw", q, v & ((i == 0) ? 8'hf0 : (i == 1) ? 8'hf7 : 8'hff));
    end
    for (i = 0; i < 14; i = i + 1) begin
      for (j = 0; j < 8; j = j + 1) begin
        bus(1'b1, `MPC_IDX_PIN1, {24'h0, i[3:0], 1'b0, j[2:0]});
        src <= $urandom;
        repeat (2) @(posedge clk);
        chk("pin", pin, pexp(i[3:0], j[2:0], src));
      end
    end
    repeat (4) @(posedge clk);
    chk("pin_in", pin_in, src[9]);
    for (i = 0; i < 6; i = i + 1) begin
      v = ctab[8*i +: 8];
      bus(1'b1, `MPC_IDX_MISC, {24'h0, v});
      e = (v[7] ? 16 : 0) + (v[6] ? (v[5] ? 40 : 20) : 0);
      start <= 1'b1;
      n = 0;
      saw = 1'b0;
      while (pwr !== 1'b1 && n < 200) begin
        @(posedge clk);
        n = n + 1;
        saw = saw | disch;
      end
      chk("pwr_delay", n >= e && n <= e + 6, 1'b1);
      chk("discharge", saw, v[7]);
      bus(1'b0, `MPC_IDX_STATUS, 32'h0);
      chk("status", q[2:0], 3'h6);
      start <= 1'b0;
      repeat (4) @(posedge clk);
    end
    for (i = 0; i < 2; i = i + 1) begin
      bus(1'b1, `MPC_IDX_MISC, {24'h0, 3'h0, i[0], 4'h0});
      run <= 1'b0;
      n = 0;
      while (hrst !== 1'b1 && n < 60) begin
        @(posedge clk);
        n = n + 1;
      end
      chk("clk_loss", n >= 25 && n <= 40, i[0]);
      run <= 1'b1;
      repeat (20) @(posedge clk);
    end
    final_report;
  end
endmodule // tb
